// file: rtl/osa_pkg.sv
// constants, state type and pilot table for the ofdm subcarrier assembler
// assumes a 100 MHz single clock; no registers reached by software
package osa_pkg;
  // ----------------------------------------------------------------
  // clock and gap times
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHORT_GAP_TIME_NS = 10000;
  localparam int BURST_GAP_TIME_NS = 2000;
  localparam int TX_TO_RX_GAP_NS = 50;
  localparam logic [9:0] SHORT_GAP_CYC = 10'((SHORT_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] BURST_GAP_CYC = 10'((BURST_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] TX_TO_RX_GAP_CYC = 10'(TX_TO_RX_GAP_NS / CLK_PERIOD_NS);
  localparam logic [9:0] GAP_ONE = 10'h001;

  // ----------------------------------------------------------------
  // symbol layout
  // ----------------------------------------------------------------
  localparam logic [6:0] BIN_FIRST = 7'h00;
  localparam logic [6:0] BIN_LAST = 7'h7F;
  localparam logic [6:0] POS_DC = 7'h40;
  localparam logic [7:0] POS_OFFSET = 8'h40;
  localparam logic [7:0] SC_LOW_EDGE = 8'hCD;
  localparam logic [7:0] SC_HIGH_EDGE = 8'h33;
  localparam logic [7:0] PILOT_OFS1 = 8'h1A;
  localparam logic [7:0] PILOT_OFS2 = 8'h34;
  localparam logic [7:0] PILOT_OFS3 = 8'h4E;
  localparam logic [3:0] PILOT_PERIOD_LAST = 4'hC;
  localparam logic [1:0] PRE_SHORT = 2'h1;
  localparam logic [1:0] PRE_LONG = 2'h3;

  // ----------------------------------------------------------------
  // pilot sequence generator
  // ----------------------------------------------------------------
  localparam logic seed_bit_high = 1'b1;
  localparam logic seed_bit_low = 1'b0;
  localparam logic [8:0] PRBS_SEED = {7'h7F, seed_bit_high, seed_bit_low};
  localparam logic [8:0] PRBS_TAPS_DEF = 9'h108;

  typedef enum logic [1:0] {OSA_IDLE, OSA_PRE, OSA_BODY, OSA_GAP} osa_state_t;

  // lowest pilot subcarrier per symbol index modulo 13, two's complement
  function automatic logic [7:0] osa_pilot_low(input logic [3:0] idx);
    logic [7:0] p;
    p = 8'hCD;
    case (idx)
      4'h0: p = 8'hCD;
      4'h1: p = 8'hD9;
      4'h2: p = 8'hE1;
      4'h3: p = 8'hD3;
      4'h4: p = 8'hDD;
      4'h5: p = 8'hE5;
      4'h6: p = 8'hCF;
      4'h7: p = 8'hD7;
      4'h8: p = 8'hDF;
      4'h9: p = 8'hD1;
      4'hA: p = 8'hE3;
      4'hB: p = 8'hDB;
      4'hC: p = 8'hD5;
      default: p = 8'hCD;
    endcase
    return p;
  endfunction
endpackage

// file: rtl/osa_skid_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock; ready and valid come straight from flip-flops
`timescale 1ns/10ps
`default_nettype none
module osa_skid_buf #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // filling side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // draining side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  logic [W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  // ----------------------------------------------------------------
  // occupancy
  // ----------------------------------------------------------------
  assign cnt_nxt = cnt_r + 2'(push) - 2'(pop);
  assign o_data = mem_r[rd_ptr_r];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 2'h0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      o_ready <= (cnt_nxt != 2'h2);
      o_valid <= (cnt_nxt != 2'h0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_data;
    end
  end
endmodule
`default_nettype wire

// file: rtl/osa_pilot_prbs.sv
// pilot polarity sequence generator, one bit per step
// assumes load and step come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module osa_pilot_prbs
  import osa_pkg::*;
#(
  parameter logic [8:0] TAPS = PRBS_TAPS_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_load,
  input wire logic i_step,
  // sequence bit
  output logic o_bit
);
  logic [8:0] lfsr_r;
  wire fb = ^(lfsr_r & TAPS);

  assign o_bit = fb;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lfsr_r <= PRBS_SEED;
    end else if (i_load) begin
      lfsr_r <= PRBS_SEED;
    end else if (i_step) begin
      lfsr_r <= {lfsr_r[7:0], fb};
    end
  end
endmodule
`default_nettype wire

// file: rtl/osa_assembler.sv
// ofdm frequency-domain symbol assembler feeding the ifft
// assumes mapper and ifft share i_clk; frame control from local logic
`timescale 1ns/10ps
`default_nettype none
module osa_assembler
  import osa_pkg::*;
#(
  parameter int W = 16,
  parameter int SYM_W = 12,
  parameter int CP_W = 7,
  parameter logic [8:0] PRBS_TAPS = PRBS_TAPS_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // frame control
  input wire logic i_frame_start,
  input wire logic i_long_pre,
  input wire logic i_burst_mode,
  input wire logic [SYM_W-1:0] i_num_sym,
  input wire logic [CP_W-1:0] i_cp_len,
  // mapper stream
  input wire logic i_map_valid,
  input wire logic [W-1:0] i_map_re,
  input wire logic [W-1:0] i_map_im,
  output logic o_map_ready,
  // ifft stream
  output logic o_ifft_valid,
  output logic [W-1:0] o_ifft_re,
  output logic [W-1:0] o_ifft_im,
  output logic [6:0] o_ifft_bin,
  output logic o_ifft_pre,
  output logic o_ifft_sos,
  input wire logic i_ifft_ready,
  // status
  output logic o_tx_ready,
  output logic o_rx_ready,
  output logic o_busy,
  output logic [CP_W-1:0] o_cp_len
);
  // ----------------------------------------------------------------
  // parameter checks and scaling
  // ----------------------------------------------------------------
  if (W < 4) begin : g_bad_w
    $error("osa_assembler: W must be at least 4");
  end
  if (SYM_W < 1 || CP_W < 1) begin : g_bad_cnt
    $error("osa_assembler: counter widths must be positive");
  end
  localparam logic [W-1:0] PILOT_POS = W'(1) << (W - 2);
  localparam logic [W-1:0] PILOT_NEG = ~PILOT_POS + W'(1);
  localparam int OW = 2 * W + 9;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  osa_state_t state_r;
  osa_state_t state_nxt;
  logic [6:0] pos_r;
  logic [1:0] pre_left_r;
  logic [SYM_W-1:0] sym_left_r;
  logic [3:0] sym_mod_r;
  logic [9:0] gap_cnt_r;
  logic [9:0] gap_target_r;

  // ----------------------------------------------------------------
  // buffers and sequence generator
  // ----------------------------------------------------------------
  logic ibuf_valid;
  logic [2*W-1:0] ibuf_data;
  logic obuf_ready;
  logic [OW-1:0] obuf_data;
  logic [OW-1:0] obuf_out;
  logic pilot_bit;

  // ----------------------------------------------------------------
  // decode signals
  // ----------------------------------------------------------------
  logic start;
  logic in_pre;
  logic in_body;
  logic [7:0] sc;
  logic [7:0] pilot_low;
  logic [7:0] pdiff;
  logic hit_pilot;
  logic in_band;
  logic is_dc;
  logic is_pilot;
  logic is_data;
  logic emitting;
  logic step;
  logic take_data;
  logic take_pilot;
  logic sym_end;
  logic last_pre;
  logic last_sym;
  logic no_body;
  logic gap_done;

  osa_skid_buf #(.W(2 * W)) u_ibuf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_map_valid),
    .i_data({i_map_re, i_map_im}),
    .o_ready(o_map_ready),
    .o_valid(ibuf_valid),
    .o_data(ibuf_data),
    .i_ready(take_data)
  );

  osa_skid_buf #(.W(OW)) u_obuf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(step),
    .i_data(obuf_data),
    .o_ready(obuf_ready),
    .o_valid(o_ifft_valid),
    .o_data(obuf_out),
    .i_ready(i_ifft_ready)
  );

  osa_pilot_prbs #(.TAPS(PRBS_TAPS)) u_prbs (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(start),
    .i_step(take_pilot),
    .o_bit(pilot_bit)
  );

  // ----------------------------------------------------------------
  // subcarrier decode
  // ----------------------------------------------------------------
  assign start = (state_r == OSA_IDLE) && i_frame_start;
  assign in_pre = (state_r == OSA_PRE);
  assign in_body = (state_r == OSA_BODY);
  assign sc = {1'b0, pos_r} - POS_OFFSET;
  assign pilot_low = osa_pilot_low(sym_mod_r);
  assign pdiff = sc - pilot_low;
  assign hit_pilot = (pdiff == 8'h00) || (pdiff == PILOT_OFS1)
    || (pdiff == PILOT_OFS2) || (pdiff == PILOT_OFS3);
  assign in_band = ($signed(sc) >= $signed(SC_LOW_EDGE))
    && ($signed(sc) <= $signed(SC_HIGH_EDGE));
  assign is_dc = (pos_r == POS_DC);
  assign is_pilot = in_body && in_band && hit_pilot;
  assign is_data = in_body && in_band && !is_dc && !hit_pilot;
  assign emitting = in_pre || in_body;
  assign step = emitting && obuf_ready && (!is_data || ibuf_valid);
  assign take_data = step && is_data;
  assign take_pilot = step && is_pilot;
  assign sym_end = step && (pos_r == BIN_LAST);
  assign last_pre = (pre_left_r == 2'h1);
  assign last_sym = (sym_left_r == SYM_W'(1));
  assign no_body = (sym_left_r == '0);
  assign gap_done = (gap_cnt_r == gap_target_r);

  // ----------------------------------------------------------------
  // bin value selection
  // ----------------------------------------------------------------
  logic [W-1:0] pilot_re;
  logic [W-1:0] val_re;
  logic [W-1:0] val_im;
  logic [6:0] bin;
  logic sos;

  assign pilot_re = pilot_bit ? PILOT_NEG : PILOT_POS;
  assign val_re = is_data ? ibuf_data[2*W-1:W] : (is_pilot ? pilot_re : '0);
  assign val_im = is_data ? ibuf_data[W-1:0] : '0;
  assign bin = pos_r ^ POS_DC;
  assign sos = (pos_r == BIN_FIRST);
  assign obuf_data = {sos, in_pre, bin, val_re, val_im};
  assign o_ifft_sos = obuf_out[OW-1];
  assign o_ifft_pre = obuf_out[OW-2];
  assign o_ifft_bin = obuf_out[OW-3:2*W];
  assign o_ifft_re = obuf_out[2*W-1:W];
  assign o_ifft_im = obuf_out[W-1:0];

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OSA_IDLE: begin
        if (i_frame_start) begin
          state_nxt = OSA_PRE;
        end
      end
      OSA_PRE: begin
        if (sym_end && last_pre) begin
          state_nxt = no_body ? OSA_GAP : OSA_BODY;
        end
      end
      OSA_BODY: begin
        if (sym_end && last_sym) begin
          state_nxt = OSA_GAP;
        end
      end
      OSA_GAP: begin
        if (gap_done) begin
          state_nxt = OSA_IDLE;
        end
      end
      default: state_nxt = OSA_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= OSA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_r <= BIN_FIRST;
    end else if (start) begin
      pos_r <= BIN_FIRST;
    end else if (step) begin
      pos_r <= pos_r + 7'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_left_r <= PRE_SHORT;
    end else if (start) begin
      pre_left_r <= i_long_pre ? PRE_LONG : PRE_SHORT;
    end else if (sym_end && in_pre) begin
      pre_left_r <= pre_left_r - 2'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sym_left_r <= '0;
      sym_mod_r <= 4'h0;
    end else if (start) begin
      sym_left_r <= i_num_sym;
      sym_mod_r <= 4'h0;
    end else if (sym_end && in_body) begin
      sym_left_r <= sym_left_r - SYM_W'(1);
      sym_mod_r <= (sym_mod_r == PILOT_PERIOD_LAST) ? 4'h0 : sym_mod_r + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cp_len <= '0;
    end else if (start) begin
      o_cp_len <= i_cp_len;
    end
  end

  // ----------------------------------------------------------------
  // interframe gap and turnaround
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_cnt_r <= GAP_ONE;
      gap_target_r <= SHORT_GAP_CYC;
    end else if (start) begin
      gap_cnt_r <= GAP_ONE;
      gap_target_r <= i_burst_mode ? BURST_GAP_CYC : SHORT_GAP_CYC;
    end else if (state_r == OSA_GAP && !gap_done) begin
      gap_cnt_r <= gap_cnt_r + GAP_ONE;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_ready <= 1'b0;
      o_rx_ready <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_tx_ready <= (state_nxt == OSA_IDLE);
      o_rx_ready <= (state_nxt == OSA_IDLE)
        || (state_nxt == OSA_GAP && gap_cnt_r >= TX_TO_RX_GAP_CYC);
      o_busy <= (state_nxt == OSA_PRE) || (state_nxt == OSA_BODY);
    end
  end
endmodule
`default_nettype wire

// file: tb/osa_assembler_checker.sv
// stream and frame checks for the subcarrier assembler
// assumes it is bound onto osa_assembler, one clock domain
`timescale 1ns/10ps
`default_nettype none
module osa_assembler_checker
  import osa_pkg::*;
#(
  parameter int W = 16,
  parameter int CP_W = 7
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_frame_start,
  input wire logic [CP_W-1:0] i_cp_len,
  input wire logic o_ifft_valid,
  input wire logic [W-1:0] o_ifft_re,
  input wire logic [W-1:0] o_ifft_im,
  input wire logic [6:0] o_ifft_bin,
  input wire logic o_ifft_pre,
  input wire logic o_ifft_sos,
  input wire logic i_ifft_ready,
  input wire logic o_tx_ready,
  input wire logic o_rx_ready,
  input wire logic o_busy,
  input wire logic [CP_W-1:0] o_cp_len
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic seen_r;
  logic [6:0] last_bin_r;
  logic zero_w;
  assign zero_w = (o_ifft_re == '0) && (o_ifft_im == '0);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_r <= 1'b0;
      last_bin_r <= 7'h00;
    end else if (o_ifft_valid && i_ifft_ready) begin
      seen_r <= 1'b1;
      last_bin_r <= o_ifft_bin;
    end
  end
  // cycles spent neither busy nor ready, i.e. inside the gap
  logic [10:0] gap_cyc_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_cyc_r <= 11'h000;
    end else if (o_busy || o_tx_ready) begin
      gap_cyc_r <= 11'h000;
    end else begin
      gap_cyc_r <= gap_cyc_r + 11'h001;
    end
  end
  sequence start_s;
    o_tx_ready && i_frame_start;
  endsequence
  sequence run_s;
    o_busy && !o_tx_ready;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  dc_zero_a: assert property (o_ifft_valid && o_ifft_bin == 7'h00 |-> zero_w) else $error("dc bin");
  guard_zero_a: assert property (o_ifft_valid && o_ifft_bin inside {[7'h34:7'h4C]} |-> zero_w)
    else $error("guard bin");
  pre_zero_a: assert property (o_ifft_valid && o_ifft_pre |-> zero_w) else $error("preamble bin");
  out_hold_a: assert property (o_ifft_valid && !i_ifft_ready |=> o_ifft_valid && $stable(o_ifft_bin)
    && $stable(o_ifft_re) && $stable(o_ifft_im)) else $error("word lost");
  sos_bin_a: assert property (o_ifft_valid && o_ifft_sos |-> o_ifft_bin == 7'h40) else $error("sos bin");
  bin_step_a: assert property (o_ifft_valid && !o_ifft_sos && seen_r |-> o_ifft_bin == last_bin_r + 7'h01)
    else $error("bin order");
  start_run_a: assert property (start_s |=> run_s) else $error("start");
  cp_take_a: assert property (start_s |=> o_cp_len == $past(i_cp_len)) else $error("cp capture");
  cp_hold_a: assert property (o_busy && $past(o_busy) |-> $stable(o_cp_len)) else $error("cp held");
  gap_min_a: assert property ($fell(o_busy) |-> !o_tx_ready [*8]) else $error("gap short");
  gap_max_a: assert property (gap_cyc_r <= 11'(SHORT_GAP_CYC)) else $error("gap long");
  rx_early_a: assert property ($fell(o_busy) |-> ##[1:8] o_rx_ready) else $error("rx turnaround");
  rx_first_a: assert property (o_tx_ready |-> o_rx_ready) else $error("rx late");
endmodule
bind osa_assembler osa_assembler_checker #(.W(W), .CP_W(CP_W)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_frame_start(i_frame_start), .i_cp_len(i_cp_len), .o_ifft_valid(o_ifft_valid), .o_ifft_re(o_ifft_re),
  .o_ifft_im(o_ifft_im), .o_ifft_bin(o_ifft_bin), .o_ifft_pre(o_ifft_pre), .o_ifft_sos(o_ifft_sos),
  .i_ifft_ready(i_ifft_ready), .o_tx_ready(o_tx_ready), .o_rx_ready(o_rx_ready), .o_busy(o_busy),
  .o_cp_len(o_cp_len));
`default_nettype wire

// file: tb/osa_far_model.sv
// far side: constellation source and ifft sink
// assumes sampling at the rising edge, drives 1 ns after it
`timescale 1ns/10ps
`default_nettype none
module osa_far_model #(
  parameter int W = 16
) (
  // clock, reset, pacing
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  // mapper side
  input wire logic i_map_ready,
  output logic o_map_valid,
  output logic [W-1:0] o_map_re,
  output logic [W-1:0] o_map_im,
  // ifft side
  output logic o_ifft_ready
);
  logic took;
  initial begin
    o_map_valid = 1'b0;
    o_map_re = '0;
    o_map_im = '0;
    o_ifft_ready = 1'b0;
  end
  // word held until taken, idle data keeps changing
  always @(posedge i_clk) begin
    took = o_map_valid && i_map_ready;
    #1;
    if (took || !o_map_valid || i_rst) begin
      o_map_valid = !i_rst && (!i_slow || $urandom_range(1, 0) == 1);
      o_map_re = W'($urandom);
      o_map_im = W'($urandom);
    end
    o_ifft_ready = !i_rst && (!i_slow || $urandom_range(3, 0) != 0);
  end
endmodule
`default_nettype wire

// file: tb/osa_assembler_tb.sv
// self-checking bench for the subcarrier assembler
// assumes default parameters and the far model beside it
`timescale 1ns/10ps
`default_nettype none
module osa_assembler_tb;
  import osa_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_frame_start = 1'b0, i_long_pre = 1'b0, i_burst_mode = 1'b0, slow = 1'b0;
  logic [11:0] i_num_sym = 12'h000;
  logic [6:0] i_cp_len = 7'h00, o_cp_len;
  logic i_map_valid, o_map_ready, o_ifft_valid, i_ifft_ready, o_ifft_pre, o_ifft_sos, o_tx_ready, o_rx_ready, o_busy;
  logic [15:0] i_map_re, i_map_im, o_ifft_re, o_ifft_im;
  logic [6:0] o_ifft_bin;
  int num_errors = 0, comparisons = 0, last_take = 0, cyc = 0;
  int eq[$];
  logic [31:0] dq[$];
  int lows[13] = '{-51, -39, -31, -45, -35, -27, -49, -41, -33, -47, -29, -37, -43};
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  osa_assembler u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_frame_start(i_frame_start), .i_long_pre(i_long_pre),
    .i_burst_mode(i_burst_mode), .i_num_sym(i_num_sym), .i_cp_len(i_cp_len), .i_map_valid(i_map_valid),
    .i_map_re(i_map_re), .i_map_im(i_map_im), .o_map_ready(o_map_ready), .o_ifft_valid(o_ifft_valid),
    .o_ifft_re(o_ifft_re), .o_ifft_im(o_ifft_im), .o_ifft_bin(o_ifft_bin), .o_ifft_pre(o_ifft_pre),
    .o_ifft_sos(o_ifft_sos), .i_ifft_ready(i_ifft_ready), .o_tx_ready(o_tx_ready), .o_rx_ready(o_rx_ready),
    .o_busy(o_busy), .o_cp_len(o_cp_len));
  osa_far_model u_far (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_map_ready(o_map_ready),
    .o_map_valid(i_map_valid), .o_map_re(i_map_re), .o_map_im(i_map_im), .o_ifft_ready(i_ifft_ready));
  // ----------------------------------------------------------------
  // compare, verdict, expected stream
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // code: bin, sos<<7, pre<<8, kind<<9 (zero, data, pilot), sign<<11
  task automatic fill(input bit lp, input int ns);
    int k, b, p, kd, sg;
    logic [8:0] lf;
    logic pb;
    lf = PRBS_SEED;
    for (int s = 0; s < ns + (lp ? 3 : 1); s++) begin
      for (int i = 0; i < 128; i++) begin
        k = i - 64;
        b = s - (lp ? 3 : 1);
        p = k - lows[b < 0 ? 0 : b % 13];
        kd = (b < 0 || k == 0 || k < -51 || k > 51) ? 0 : (p >= 0 && p <= 78 && p % 26 == 0) ? 2 : 1;
        pb = ^(lf & PRBS_TAPS_DEF);
        if (kd == 2) lf = {lf[7:0], pb};
        sg = (b < 2) ? ((b == 0) == (p == 78)) : pb;
        eq.push_back((i + 64) % 128 + (i == 0) * 128 + (b < 0) * 256 + kd * 512 + sg * 2048);
      end
    end
  endtask
  always @(posedge i_clk) begin
    int c;
    logic [31:0] d;
    if (!i_rst && i_map_valid && o_map_ready) dq.push_back({i_map_re, i_map_im});
    if (!i_rst && o_ifft_valid && i_ifft_ready) begin
      last_take = cyc;
      c = (eq.size() > 0) ? eq.pop_front() : -1;
      check({o_ifft_pre, o_ifft_sos, o_ifft_bin}, c[8:0]);
      d = 32'h0000_0000;
      if (c[10:9] == 2'h1) d = dq.pop_front();
      if (c[10:9] >= 2'h2) d = {c[11] ? 16'hC000 : 16'h4000, 16'h0000};
      check({o_ifft_re, o_ifft_im}, d);
    end
  end
  task automatic run_frame(input bit lp, input bit bm, input int ns);
    logic [6:0] cp;
    int lim;
    fill(lp, ns);
    cp = 7'($urandom);
    @(posedge i_clk);
    #1;
    {i_long_pre, i_burst_mode, i_num_sym, i_cp_len, i_frame_start} = {lp, bm, 12'(ns), cp, 1'b1};
    @(posedge i_clk);
    #1;
    i_frame_start = 1'b0;
    check(o_cp_len, cp);
    repeat (150) @(posedge i_clk);
    #1;
    {i_frame_start, i_cp_len} = {1'b1, ~cp};
    @(posedge i_clk);
    #1;
    i_frame_start = 1'b0;
    lim = 0;
    while ((eq.size() > 0 || o_tx_ready !== 1'b1) && lim < 22000) begin
      @(posedge i_clk);
      #1;
      lim++;
    end
    if (lim >= 22000) begin
      num_errors++;
      give_verdict;
    end else begin
      check((cyc - last_take) inside {[(bm ? 200 : 1000) - 12:(bm ? 200 : 1000) + 1]}, 1'b1);
      check(o_rx_ready, 1'b1);
      check(o_cp_len, cp);
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(68));
    repeat (3) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    @(posedge i_clk);
    #1;
    check(o_tx_ready, 1'b1);
    run_frame(1'b0, 1'b0, 15);
    slow = 1'b1;
    run_frame(1'b1, 1'b1, 2);
    run_frame(1'b1, 1'b1, 0);
    fill(1'b0, 1);
    {i_long_pre, i_num_sym, i_frame_start} = {1'b0, 12'h001, 1'b1};
    @(posedge i_clk);
    #1;
    i_frame_start = 1'b0;
    repeat (60) @(posedge i_clk);
    #1;
    i_rst = 1'b1;
    eq.delete();
    dq.delete();
    @(posedge i_clk);
    #1;
    check({o_busy, o_ifft_valid}, 2'h0);
    i_rst = 1'b0;
    slow = 1'b0;
    run_frame(1'b0, 1'b0, 1);
    give_verdict;
  end
endmodule
`default_nettype wire
